// File: src/uph_top.v
// Received packet header writer with payload store, plus transmit page
// release control, behind an AXI4-Lite register slave.
// Assumes serial interface engine strobes are on core_clk, and that no new
// packet starts while rx_busy is high.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "uph_defines.vh"

// Function
// - page release auto or manual; pop always
// - eight-byte header before payload in RAM
// - engine part writes header bytes 0..5
// - header DMA part writes bytes 6,7
// - endpoint, packet ID, address fields, zero padded
// - toggle repeat flag when toggle unchanged
// - store received toggle in byte 0 bit 6
// - CRC error flag in byte 0 bit 7
// - frame count into bytes 4 and 5
// - byte count payload plus eight, bytes 6,7
// - payload stored in order from offset 8
module uph_top #(
   parameter MEM_AW = 12,
   parameter NUM_EP = 16
) (
   input  wire                    core_clk,
   input  wire                    rst,
   // AXI4-Lite slave
   input  wire [`UPH_AXI_AW-1:0]  s_axi_awaddr,
   input  wire                    s_axi_awvalid,
   output reg                     s_axi_awready,
   input  wire [31:0]             s_axi_wdata,
   input  wire [3:0]              s_axi_wstrb,
   input  wire                    s_axi_wvalid,
   output reg                     s_axi_wready,
   output reg  [1:0]              s_axi_bresp,
   output reg                     s_axi_bvalid,
   input  wire                    s_axi_bready,
   input  wire [`UPH_AXI_AW-1:0]  s_axi_araddr,
   input  wire                    s_axi_arvalid,
   output reg                     s_axi_arready,
   output reg  [31:0]             s_axi_rdata,
   output reg  [1:0]              s_axi_rresp,
   output reg                     s_axi_rvalid,
   input  wire                    s_axi_rready,
   // Serial interface engine, receive side
   input  wire                    rx_start,
   input  wire [MEM_AW-1:0]       rx_base,
   input  wire [3:0]              rx_endpoint,
   input  wire [3:0]              rx_packet_id,
   input  wire [6:0]              rx_target_address,
   input  wire                    rx_toggle,
   input  wire [15:0]             rx_frame_count,
   input  wire                    rx_data_valid,
   input  wire [7:0]              rx_data,
   input  wire                    rx_end,
   input  wire                    rx_crc_error,
   output reg                     rx_busy,
   // Buffer RAM write port
   output reg                     mem_we,
   output reg  [MEM_AW-1:0]       mem_addr,
   output reg  [7:0]              mem_wdata,
   // Transmit completion towards the page manager
   input  wire                    tx_done,
   input  wire [7:0]              tx_packet_num,
   output reg                     tx_queue_pop,
   output reg                     page_free,
   output reg  [7:0]              page_free_num,
   output reg                     manual_page_release,
   output reg                     irq
);

   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_LOAD = 4'b0010;
   localparam [3:0] ST_HDR  = 4'b0100;
   localparam [3:0] ST_DMA  = 4'b1000;

   function [15:0] reg_index;
      input [`UPH_AXI_AW-1:0] addr;
      begin
         reg_index = addr[`UPH_AXI_AW-1:2];
      end
   endfunction

   function known_index;
      input [15:0] idx;
      begin
         known_index = (idx == `UPH_IDX_PAGE_CTRL) || (idx == `UPH_IDX_IRQ_STATUS) ||
                       (idx == `UPH_IDX_IRQ_MASK) || (idx == `UPH_IDX_LAST_COUNT);
      end
   endfunction

   reg  [3:0]             state;
   reg  [MEM_AW-1:0]      base;
   reg  [3:0]             endpoint;
   reg  [3:0]             packet_id;
   reg  [6:0]             target_address;
   reg                    received_toggle_value;
   reg                    toggle_repeat_flag;
   reg                    crc_error;
   reg  [15:0]            frame_count;
   reg  [10:0]            byte_count;
   reg  [2:0]             hdr_off;
   reg  [NUM_EP-1:0]      last_toggle;
   reg  [`UPH_IRQ_W-1:0]  irq_status;
   reg  [`UPH_IRQ_W-1:0]  irq_mask;
   reg  [10:0]            last_count;
   reg  [`UPH_IRQ_W-1:0]  events;
   reg  [`UPH_IRQ_W-1:0]  next_status;
   reg  [31:0]            next_rdata;
   wire [7:0]             hdr_byte;
   wire [15:0]            wr_idx;
   wire [15:0]            rd_idx;
   wire                   wr_go;
   wire                   rd_go;

   assign wr_idx = reg_index(s_axi_awaddr);
   assign rd_idx = reg_index(s_axi_araddr);
   assign wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   assign rd_go  = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

   uph_hdr_fmt u_fmt (
      .offset                (hdr_off),
      .endpoint              (endpoint),
      .packet_id             (packet_id),
      .target_address        (target_address),
      .received_toggle_value (received_toggle_value),
      .toggle_repeat_flag    (toggle_repeat_flag),
      .crc_error             (crc_error),
      .frame_count           (frame_count),
      .byte_count            (byte_count),
      .hdr_byte              (hdr_byte)
   );

   ////////////////////////////////////////////////////////////////////////
   // Receive packet store

   always @(posedge core_clk) begin
      if (rst) begin
         state                 <= ST_IDLE;
         base                  <= {MEM_AW{1'b0}};
         endpoint              <= 4'h0;
         packet_id             <= 4'h0;
         target_address        <= 7'h00;
         received_toggle_value <= 1'b0;
         toggle_repeat_flag    <= 1'b0;
         crc_error             <= 1'b0;
         frame_count           <= 16'h0000;
         byte_count            <= `UPH_HDR_LEN;
         hdr_off               <= 3'h0;
         // Expect DATA0 first, so all-ones marks the previous toggle as 1
         last_toggle           <= {NUM_EP{1'b1}};
         rx_busy               <= 1'b0;
         mem_we                <= 1'b0;
         mem_addr              <= {MEM_AW{1'b0}};
         mem_wdata             <= 8'h00;
         last_count            <= 11'h000;
      end else begin
         mem_we <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (rx_start) begin
                  state                 <= ST_LOAD;
                  rx_busy               <= 1'b1;
                  base                  <= rx_base;
                  endpoint              <= rx_endpoint;
                  packet_id             <= rx_packet_id;
                  target_address        <= rx_target_address;
                  received_toggle_value <= rx_toggle;
                  toggle_repeat_flag    <= (rx_toggle == last_toggle[rx_endpoint]);
                  last_toggle[rx_endpoint] <= rx_toggle;
                  frame_count           <= rx_frame_count;
                  byte_count            <= `UPH_HDR_LEN;
               end
            end
            ST_LOAD: begin
               if (rx_data_valid) begin
                  mem_we     <= 1'b1;
                  // Payload lands after the header, in arrival order
                  mem_addr   <= base + {{(MEM_AW-11){1'b0}}, byte_count};
                  mem_wdata  <= rx_data;
                  byte_count <= byte_count + 11'h001;
               end else if (rx_end) begin
                  crc_error <= rx_crc_error;
                  hdr_off   <= `UPH_OFF_EP;
                  state     <= ST_HDR;
               end
            end
            ST_HDR: begin
               mem_we    <= 1'b1;
               mem_addr  <= base + {{(MEM_AW-3){1'b0}}, hdr_off};
               mem_wdata <= hdr_byte;
               hdr_off   <= hdr_off + 3'h1;
               if (hdr_off == `UPH_OFF_FRM_HI)
                  state <= ST_DMA;
            end
            ST_DMA: begin
               // Count bytes written only once the payload is complete
               mem_we    <= 1'b1;
               mem_addr  <= base + {{(MEM_AW-3){1'b0}}, hdr_off};
               mem_wdata <= hdr_byte;
               hdr_off   <= hdr_off + 3'h1;
               if (hdr_off == `UPH_OFF_CNT_HI) begin
                  state      <= ST_IDLE;
                  rx_busy    <= 1'b0;
                  last_count <= byte_count;
               end
            end
            default: begin
               state   <= ST_IDLE;
               rx_busy <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit page release

   always @(posedge core_clk) begin
      if (rst) begin
         tx_queue_pop  <= 1'b0;
         page_free     <= 1'b0;
         page_free_num <= 8'h00;
      end else begin
         // Queue pops in both modes; only the page return is suppressed
         tx_queue_pop  <= tx_done;
         page_free     <= tx_done && !manual_page_release;
         if (tx_done)
            page_free_num <= tx_packet_num;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt events

   always @* begin
      events = {`UPH_IRQ_W{1'b0}};
      events[`UPH_IRQ_STORED] = (state == ST_DMA) && (hdr_off == `UPH_OFF_CNT_HI);
      events[`UPH_IRQ_CRC]    = (state == ST_LOAD) && !rx_data_valid && rx_end &&
                                rx_crc_error;
      events[`UPH_IRQ_TOGREP] = (state == ST_IDLE) && rx_start &&
                                (rx_toggle == last_toggle[rx_endpoint]);
      events[`UPH_IRQ_TXDONE] = tx_done;
      next_status = irq_status;
      if (wr_go && (wr_idx == `UPH_IDX_IRQ_STATUS) && s_axi_wstrb[0])
         next_status = next_status & ~s_axi_wdata[`UPH_IRQ_W-1:0];
      // A new event beats a simultaneous clear
      next_status = next_status | events;
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite register slave

   always @* begin
      next_rdata = 32'h0000_0000;
      case (rd_idx)
         `UPH_IDX_PAGE_CTRL:  next_rdata[`UPH_BIT_MANUAL] = manual_page_release;
         `UPH_IDX_IRQ_STATUS: next_rdata[`UPH_IRQ_W-1:0] = irq_status;
         `UPH_IDX_IRQ_MASK:   next_rdata[`UPH_IRQ_W-1:0] = irq_mask;
         `UPH_IDX_LAST_COUNT: next_rdata[10:0] = last_count;
         default:             next_rdata = 32'h0000_0000;
      endcase
   end

   always @(posedge core_clk) begin
      if (rst) begin
         s_axi_awready       <= 1'b0;
         s_axi_wready        <= 1'b0;
         s_axi_bvalid        <= 1'b0;
         s_axi_bresp         <= `UPH_RESP_OKAY;
         s_axi_arready       <= 1'b0;
         s_axi_rvalid        <= 1'b0;
         s_axi_rresp         <= `UPH_RESP_OKAY;
         s_axi_rdata         <= 32'h0000_0000;
         manual_page_release <= `UPH_MANUAL_RST;
         irq_status          <= {`UPH_IRQ_W{1'b0}};
         irq_mask            <= {`UPH_IRQ_W{1'b0}};
         irq                 <= 1'b0;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready  <= wr_go;
         s_axi_arready <= rd_go;
         irq_status    <= next_status;
         irq           <= |(next_status & irq_mask);
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known_index(wr_idx) ? `UPH_RESP_OKAY : `UPH_RESP_SLVERR;
            if (s_axi_wstrb[0]) begin
               // Firmware is trusted to change the mode only while idle
               if (wr_idx == `UPH_IDX_PAGE_CTRL)
                  manual_page_release <= s_axi_wdata[`UPH_BIT_MANUAL];
               if (wr_idx == `UPH_IDX_IRQ_MASK)
                  irq_mask <= s_axi_wdata[`UPH_IRQ_W-1:0];
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= known_index(rd_idx) ? `UPH_RESP_OKAY : `UPH_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// File: src/uph_defines.vh
// Constants for the packet header writer and page release control.
// Included by every design file; definitions only.
`ifndef UPH_DEFINES_VH
`define UPH_DEFINES_VH

// Register indices; byte address is four times the index
`define UPH_IDX_PAGE_CTRL   16'h7f67
`define UPH_IDX_IRQ_STATUS  16'h7f70
`define UPH_IDX_IRQ_MASK    16'h7f71
`define UPH_IDX_LAST_COUNT  16'h7f72
`define UPH_AXI_AW          18
`define UPH_PAGE_CTRL_RST   8'h00
`define UPH_MANUAL_RST      1'b0
`define UPH_BIT_MANUAL      0

// Interrupt status bit positions
`define UPH_IRQ_STORED      0
`define UPH_IRQ_CRC         1
`define UPH_IRQ_TOGREP      2
`define UPH_IRQ_TXDONE      3
`define UPH_IRQ_W           4

// Header layout
`define UPH_OFF_EP          3'h0
`define UPH_OFF_PID         3'h1
`define UPH_OFF_ADDR        3'h2
`define UPH_OFF_RSVD        3'h3
`define UPH_OFF_FRM_LO      3'h4
`define UPH_OFF_FRM_HI      3'h5
`define UPH_OFF_CNT_LO      3'h6
`define UPH_OFF_CNT_HI      3'h7
`define UPH_HDR_LEN         11'h008
`define UPH_BIT_CRC         7
`define UPH_BIT_TOGGLE      6
`define UPH_BIT_TOGREP      5

// AXI responses
`define UPH_RESP_OKAY       2'h0
`define UPH_RESP_SLVERR     2'h2

`endif

// File: src/uph_hdr_fmt.v
// Header byte formatter: maps a header offset to the byte stored there.
// Assumes all field inputs are held stable by the caller while writing.
`timescale 1ns/100ps
`include "uph_defines.vh"

module uph_hdr_fmt (
   input  wire [2:0]  offset,
   input  wire [3:0]  endpoint,
   input  wire [3:0]  packet_id,
   input  wire [6:0]  target_address,
   input  wire        received_toggle_value,
   input  wire        toggle_repeat_flag,
   input  wire        crc_error,
   input  wire [15:0] frame_count,
   input  wire [10:0] byte_count,
   output reg  [7:0]  hdr_byte
);

   always @* begin
      case (offset)
         `UPH_OFF_EP:     hdr_byte = {crc_error, received_toggle_value,
                                      toggle_repeat_flag, 1'b0, endpoint};
         `UPH_OFF_PID:    hdr_byte = {4'h0, packet_id};
         `UPH_OFF_ADDR:   hdr_byte = {1'b0, target_address};
         `UPH_OFF_RSVD:   hdr_byte = 8'h00;
         `UPH_OFF_FRM_LO: hdr_byte = frame_count[7:0];
         `UPH_OFF_FRM_HI: hdr_byte = frame_count[15:8];
         `UPH_OFF_CNT_LO: hdr_byte = byte_count[7:0];
         `UPH_OFF_CNT_HI: hdr_byte = {5'h00, byte_count[10:8]};
         default:         hdr_byte = 8'h00;
      endcase
   end

endmodule

// File: bench/uph_fw_model.sv
// Firmware-side model: buffer RAM image and manual page freeing.
// Assumes a 12-bit byte address on the RAM write port.
`timescale 1ns/100ps
module uph_fw_model (
   input logic        core_clk,
   input logic        rst,
   input logic        mem_we,
   input logic [11:0] mem_addr,
   input logic [7:0]  mem_wdata,
   input logic        tx_queue_pop,
   input logic        manual_page_release
);
   logic [7:0] ram [4096];
   int         fw_freed;
   // Non-zero fill 8'hc3, so an unwritten byte reads as a match only where 8'hc3 is expected
   initial for (int i = 0; i < 4096; i++) ram[i] = 8'hc3;
   always @(posedge core_clk) begin
      if (mem_we)
         ram[mem_addr] <= mem_wdata;
      if (rst)
         fw_freed <= 0;
      else if (tx_queue_pop && manual_page_release)
         fw_freed <= fw_freed + 1;
   end
endmodule

// File: bench/uph_asserts.sv
// Port checker for the header writer and page release control.
// Bound into uph_top; single clock domain.
`timescale 1ns/100ps
module uph_chk (
   input logic        core_clk,
   input logic        rst,
   input logic        s_axi_awvalid,
   input logic        s_axi_wvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic        rx_start,
   input logic        rx_end,
   input logic        rx_data_valid,
   input logic        rx_busy,
   input logic        mem_we,
   input logic        tx_done,
   input logic        tx_queue_pop,
   input logic        page_free,
   input logic        manual_page_release
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_end;
      rx_end && rx_busy && !rx_data_valid;
   endsequence
   sequence s_hdr;
      mem_we [*8];
   endsequence
   AST_BUSY_START: assert property (rx_start && !rx_busy |=> rx_busy)
      else $error("busy not raised");
   AST_DATA_WR: assert property (rx_busy && rx_data_valid |=> mem_we)
      else $error("payload byte not written");
   AST_HDR_BURST: assert property (s_end |=> !mem_we ##1 s_hdr ##1 !mem_we)
      else $error("header not eight writes");
   AST_HDR_BUSY: assert property (s_end |=> rx_busy [*8] ##1 !rx_busy)
      else $error("busy span wrong");
   AST_POP: assert property (tx_done |=> tx_queue_pop)
      else $error("queue pop missing");
   AST_AUTO: assert property (tx_done && !manual_page_release |=> page_free)
      else $error("auto free missing");
   AST_MANUAL: assert property (tx_done && manual_page_release |=> !page_free)
      else $error("free in manual mode");
   AST_FREE_CAUSE: assert property (page_free |-> $past(tx_done))
      else $error("stray page free");
   AST_WR_ACK: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
      !s_axi_bvalid |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
      else $error("write not answered");
   AST_RD_ACK: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
      |=> s_axi_arready && s_axi_rvalid)
      else $error("read not answered");
   AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer stuck");
endmodule
bind uph_top uph_chk u_chk (.core_clk, .rst, .s_axi_awvalid, .s_axi_wvalid,
   .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .rx_start, .rx_end, .rx_data_valid, .rx_busy,
   .mem_we, .tx_done, .tx_queue_pop, .page_free, .manual_page_release);

// File: bench/tb_top.sv
// Self-checking bench: registers, packet store, page release, interrupt.
// Assumes the firmware model captures every RAM write.
`timescale 1ns/100ps
`include "uph_defines.vh"
module tb_top;
   logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf, rx_endpoint = 0, rx_packet_id = 0;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [11:0] rx_base = 0, mem_addr;
   logic [7:0]  rx_data = 0, mem_wdata, tx_packet_num = 0, page_free_num;
   logic [6:0]  rx_target_address = 0;
   logic [15:0] rx_frame_count = 0;
   logic        core_clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, tx_done = 0;
   logic        rx_start = 0, rx_toggle = 0, rx_data_valid = 0, rx_end = 0;
   logic        rx_crc_error = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, rx_busy, mem_we, tx_queue_pop;
   logic        page_free, manual_page_release, irq;
   int          errors = 0, n_tests = 0;
   uph_top uut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_start, .rx_base,
      .rx_endpoint, .rx_packet_id, .rx_target_address, .rx_toggle, .rx_frame_count,
      .rx_data_valid, .rx_data, .rx_end, .rx_crc_error, .rx_busy, .mem_we, .mem_addr,
      .mem_wdata, .tx_done, .tx_packet_num, .tx_queue_pop, .page_free,
      .page_free_num, .manual_page_release, .irq);
   uph_fw_model mdl (.core_clk, .rst, .mem_we, .mem_addr, .mem_wdata, .tx_queue_pop,
      .manual_page_release);
   always #10 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr(input [15:0] idx, input [31:0] d, output [1:0] r);
      @(posedge core_clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_awvalid <= 0;
      s_axi_wvalid <= 0;
      s_axi_bready <= 0;
   endtask
   task rd(input [15:0] idx, output [31:0] d, output [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_arvalid <= 0;
      s_axi_rready <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      rd(`UPH_IDX_PAGE_CTRL, d, r);
      chk(r, `UPH_RESP_OKAY);
      chk(d, `UPH_PAGE_CTRL_RST);
      wr(`UPH_IDX_PAGE_CTRL, 32'h000000ff, r);
      chk(r, `UPH_RESP_OKAY);
      wr(16'h7f7e, 32'h1, r);
      chk(r, `UPH_RESP_SLVERR);
      rd(`UPH_IDX_PAGE_CTRL, d, r);
      chk(d, 32'h1);
      rd(16'h7f7e, d, r);
      chk(r, `UPH_RESP_SLVERR);
      chk(d, 32'h0);
   endtask
   task t_tx(input logic m);
      logic [1:0] r;
      int         f;
      wr(`UPH_IDX_PAGE_CTRL, {31'h0, m}, r);
      repeat (3) @(posedge core_clk);
      f = mdl.fw_freed;
      tx_done <= 1;
      tx_packet_num <= 8'h5c + m;
      @(posedge core_clk);
      tx_done <= 0;
      @(posedge core_clk);
      chk(tx_queue_pop, 1);
      chk(page_free, !m);
      chk(page_free_num, 8'h5c + m);
      chk(manual_page_release, m);
      repeat (2) @(posedge core_clk);
      chk(mdl.fw_freed, f + m);
   endtask
   task t_pkt(input [3:0] ep, pid, input [6:0] ta, input tg, rep, crc,
              input [15:0] fr, input [11:0] b, input int n);
      logic [7:0]  h [8];
      logic [10:0] c;
      c = 11'(n + 8);
      h = '{{crc, tg, rep, 1'b0, ep}, {4'h0, pid}, {1'b0, ta}, 8'h00,
            fr[7:0], fr[15:8], c[7:0], {5'h0, c[10:8]}};
      @(posedge core_clk);
      rx_start <= 1;
      rx_base <= b;
      rx_endpoint <= ep;
      rx_packet_id <= pid;
      rx_target_address <= ta;
      rx_toggle <= tg;
      rx_frame_count <= fr;
      @(posedge core_clk);
      rx_start <= 0;
      for (int k = 0; k < n; k++) begin
         rx_data_valid <= 1;
         rx_data <= 8'(8'ha0 + k);
         @(posedge core_clk);
      end
      rx_data_valid <= 0;
      rx_end <= 1;
      rx_crc_error <= crc;
      @(posedge core_clk);
      rx_end <= 0;
      do @(posedge core_clk); while (rx_busy !== 1'b0);
      repeat (2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) chk(mdl.ram[b + i], h[i]);
      for (int k = 0; k < n; k++) chk(mdl.ram[b + 8 + k], 8'(8'ha0 + k));
   endtask
   task t_irq;
      logic [31:0] d;
      logic [1:0]  r;
      wr(`UPH_IDX_IRQ_MASK, 32'h0, r);
      repeat (3) @(posedge core_clk);
      chk(irq, 0);
      wr(`UPH_IDX_IRQ_MASK, 32'h1 << `UPH_IRQ_STORED, r);
      repeat (3) @(posedge core_clk);
      chk(irq, 1);
      wr(`UPH_IDX_IRQ_STATUS, 32'h1 << `UPH_IRQ_STORED, r);
      repeat (3) @(posedge core_clk);
      chk(irq, 0);
      rd(`UPH_IDX_IRQ_STATUS, d, r);
      chk(d[`UPH_IRQ_STORED], 0);
      chk(d[`UPH_IRQ_CRC], 1);
      chk(d[`UPH_IRQ_TOGREP], 1);
      chk(d[`UPH_IRQ_TXDONE], 1);
      rd(`UPH_IDX_LAST_COUNT, d, r);
      chk(d, 32'd250 + `UPH_HDR_LEN);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("tests=%0d errors=%0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 0;
      t_regs;
      t_tx(0);
      t_tx(1);
      // First use of each endpoint compares against a stored toggle of one
      t_pkt(4'h3, 4'hf, 7'h7f, 0, 0, 0, 16'hffff, 12'h100, 3);
      t_pkt(4'h3, 4'h3, 7'h01, 0, 1, 1, 16'h0801, 12'h200, 0);
      t_pkt(4'hf, 4'h9, 7'h2a, 1, 1, 0, 16'h07ff, 12'h240, 1);
      t_pkt(4'h3, 4'h1, 7'h40, 1, 0, 0, 16'hf800, 12'h300, 250);
      t_irq;
      end_sim;
   end
   // Cut a hang short well past the few hundred cycles the tests take
   initial begin
      #500000;
      errors++;
      end_sim;
   end
endmodule
